// file: hw/quad_read_dev.sv
// flash device end: quad-line read decode, latency and data return
// Summary of operation
// R1: EBh uses config address length; ECh four bytes
// R2: address enters four bits per clock
// R3: quad read accepted only when quad enabled
// R4: host keeps serial clock at most 133 MHz
// R5: latency-code dummy cycles follow the mode cycles
// R6: line values ignored during dummy cycles
// R7: one nibble per clock, changed on falling edge
// R8: any start byte; address increments per byte
// R9: address wraps to zero past highest location
// R10: mode nibble A keeps continuous read, no opcode
// R11: lower mode nibble is ignored
// R12: other mode nibble leaves continuous mode at deselect
// R13: mode reset command leaves continuous mode
// R14: two mode cycles follow last address cycle
// R15: host releases lines by first data fall
// R16: host may release lines from last mode cycle
// R17: host keeps select low through mode and dummy
// R18: four-line protocol sends opcode four bits per clock
// R19: opcode lasts eight cycles, two in four-line protocol; continuous mode skips it
// R20: select high during data ends the read
// R21: msb first, line zero carries nibble lsb
`timescale 1ns/1ps
`default_nettype none
module quad_read_dev (
    // clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_i,
    // link
    quad_read_if.dev                           link,
    // configuration bits
    input  wire logic                          quad_en_i,
    input  wire logic                          addr4_i,
    input  wire logic                          all_four_line_protocol_i,
    input  wire logic [3:0]                    latency_i,
    // array preload
    input  wire logic                          load_en_i,
    input  wire logic [quad_read_pkg::MEM_AW-1:0] load_addr_i,
    input  wire logic [7:0]                    load_data_i,
    // status
    output logic                               cont_mode_o,
    output logic                               reading_o
);
    import quad_read_pkg::*;

    typedef logic [MEM_AW-1:0] maddr_t;

    logic [7:0] mem [0:(1 << MEM_AW) - 1];

    phase_e     ph_reg;
    logic [3:0] cnt_reg;
    logic       sck_q_reg;
    logic [7:0] opc_reg;
    logic [31:0] adr_sh_reg;
    logic       wide_reg;
    logic [3:0] lat_reg;
    logic [3:0] mode_hi_reg;
    logic       mode_seen_reg;
    logic       cont_reg;
    maddr_t     rd_addr_reg;
    logic       nib_lo_reg;
    logic [3:0] dout_reg;
    logic       oe_n_reg;

    logic       rise;
    logic       fall;
    logic       frame_end;
    logic       frame_start;
    logic [7:0] opc_next;
    logic [31:0] adr_next;
    logic       last_cyc;
    logic [7:0] cur_byte;

    // serial clock is a plain input sampled on the system clock
    assign rise        = link.sck && !sck_q_reg;
    assign fall        = !link.sck && sck_q_reg;
    assign frame_end   = link.cs_n && (ph_reg != PH_IDLE);
    assign frame_start = !link.cs_n && (ph_reg == PH_IDLE);
    assign cur_byte    = mem[rd_addr_reg];

    // R18 opcode nibble-wide in four-line protocol
    // R21 msb first, line zero is the lsb
    assign opc_next = all_four_line_protocol_i ? {opc_reg[3:0], link.io_line}
                                               : {opc_reg[6:0], link.io_line[0]};
    // R2 address nibble per rising edge
    assign adr_next = {adr_sh_reg[27:0], link.io_line};

    // last cycle of the current counted phase
    always_comb begin
        unique case (ph_reg)
            PH_OPC:   last_cyc = (cnt_reg == opc_cycles(all_four_line_protocol_i) - 4'h1);
            PH_ADDR:  last_cyc = (cnt_reg == adr_cycles(wide_reg) - 4'h1);
            PH_MODE:  last_cyc = (cnt_reg == MODE_CYC - 4'h1);
            PH_DUMMY: last_cyc = (cnt_reg == lat_reg - 4'h1);
            default:  last_cyc = 1'b0;
        endcase
    end

    // edge history of the serial clock
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q_reg <= 1'b0;
        end else begin
            sck_q_reg <= link.sck;
        end
    end

    // array preload port; contents are not reset
    always_ff @(posedge clk_sys_i) begin
        if (load_en_i) begin
            mem[load_addr_i] <= load_data_i;
        end
    end

    // frame phase sequencing
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ph_reg  <= PH_IDLE;
            cnt_reg <= 4'h0;
        end else if (link.cs_n) begin
            // R20 deselect ends the read anywhere
            ph_reg  <= PH_IDLE;
            cnt_reg <= 4'h0;
        end else if (frame_start) begin
            // R19 continuous mode skips the opcode
            ph_reg  <= cont_reg ? PH_ADDR : PH_OPC;
            cnt_reg <= 4'h0;
        end else if (rise && ph_reg != PH_DATA && ph_reg != PH_IGNORE) begin
            cnt_reg <= last_cyc ? 4'h0 : cnt_reg + 4'h1;
            if (last_cyc) begin
                unique case (ph_reg)
                    PH_OPC: begin
                        // R3 quad read needs quad enable
                        if (quad_en_i && (opc_next == OP_QREAD ||
                                          opc_next == OP_QREAD_WIDE)) begin
                            ph_reg <= PH_ADDR;
                        end else begin
                            ph_reg <= PH_IGNORE;
                        end
                    end
                    // R14 two mode cycles right after address
                    PH_ADDR:  ph_reg <= PH_MODE;
                    // R5 dummy cycles, none when code is zero
                    PH_MODE:  ph_reg <= (lat_reg == 4'h0) ? PH_DATA : PH_DUMMY;
                    PH_DUMMY: ph_reg <= PH_DATA;
                    default:  ph_reg <= PH_IGNORE;
                endcase
            end else if (ph_reg == PH_ADDR && cont_reg && cnt_reg == 4'h1 &&
                         adr_next[7:0] == OP_MODE_RST) begin
                // R13 mode reset seen where the address would start
                ph_reg <= PH_IGNORE;
            end
        end
    end

    // opcode and address shifters
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            opc_reg    <= 8'h00;
            adr_sh_reg <= 32'h0000_0000;
        end else if (rise && ph_reg == PH_OPC) begin
            opc_reg <= opc_next;
        end else if (rise && ph_reg == PH_ADDR) begin
            adr_sh_reg <= adr_next;
        end
    end

    // address length and latency are fixed at frame start or opcode end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wide_reg <= 1'b0;
            lat_reg  <= 4'h0;
        end else if (frame_start) begin
            wide_reg <= addr4_i;
            lat_reg  <= latency_i;
        end else if (rise && ph_reg == PH_OPC && last_cyc) begin
            // R1 wide opcode forces four address bytes
            wide_reg <= (opc_next == OP_QREAD_WIDE) ? 1'b1 : addr4_i;
        end
    end

    // mode byte capture
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_hi_reg   <= MODE_EXIT;
            mode_seen_reg <= 1'b0;
        end else if (frame_start) begin
            mode_seen_reg <= 1'b0;
        end else if (rise && ph_reg == PH_MODE && cnt_reg == 4'h0) begin
            // R11 only the upper nibble is kept
            mode_hi_reg   <= link.io_line;
            mode_seen_reg <= 1'b1;
        end
    end

    // continuous read state, decided when select rises, cleared earlier by a mode reset in the address phase
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cont_reg <= 1'b0;
        end else if (rise && ph_reg == PH_ADDR && cont_reg && cnt_reg == 4'h1 &&
                     adr_next[7:0] == OP_MODE_RST) begin
            // R13 mode reset drops continuous read
            cont_reg <= 1'b0;
        end else if (frame_end && mode_seen_reg) begin
            // R10 nibble A keeps it
            // R12 anything else leaves at deselect
            cont_reg <= (mode_hi_reg == MODE_KEEP);
        end
    end

    // read address: loaded after the address phase, stepped per byte
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_addr_reg <= '0;
        end else if (rise && ph_reg == PH_ADDR && last_cyc) begin
            // R8 any byte location may start
            rd_addr_reg <= adr_next[MEM_AW-1:0];
        end else if (fall && ph_reg == PH_DATA && nib_lo_reg) begin
            // R8 step after each byte
            // R9 wraps to zero by width
            rd_addr_reg <= rd_addr_reg + maddr_t'(1);
        end
    end

    // data return; lines stay released until the first data fall
    // R6 nothing is sampled during dummy cycles
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nib_lo_reg <= 1'b0;
            dout_reg   <= 4'h0;
            oe_n_reg   <= 1'b1;
        end else if (ph_reg != PH_DATA || link.cs_n) begin
            nib_lo_reg <= 1'b0;
            oe_n_reg   <= 1'b1;
        end else if (fall) begin
            // R7 nibble changes on the falling edge, upper first
            nib_lo_reg <= !nib_lo_reg;
            dout_reg   <= nib_lo_reg ? cur_byte[3:0] : cur_byte[7:4];
            oe_n_reg   <= 1'b0;
        end
    end

    // link outputs
    assign link.dev_io      = dout_reg;
    assign link.dev_io_oe_n = oe_n_reg;

    // status outputs
    assign cont_mode_o = cont_reg;
    assign reading_o   = (ph_reg == PH_DATA);

endmodule
`default_nettype wire

// file: hw/quad_read_host.sv
// controller end: issues quad reads and buffers returned bytes
`timescale 1ns/1ps
`default_nettype none
module quad_read_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  buf_mem [0:D-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_reg != (AW+1)'(D));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = buf_mem[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            buf_mem[wr_reg] <= in_data_i;
        end
    end

    // pointers and fill level; depth is a power of two so pointers wrap
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module quad_read_host (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // link
    quad_read_if.host        link,
    // read request
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [31:0] req_addr_i,
    input  wire logic        req_wide_i,
    input  wire logic        req_stay_i,
    input  wire logic [7:0]  req_len_i,
    // mirror of device configuration
    input  wire logic        cfg_addr4_i,
    input  wire logic        cfg_qpi_i,
    input  wire logic [3:0]  cfg_latency_i,
    // returned bytes
    output logic             rd_valid_o,
    input  wire logic        rd_ready_i,
    output logic [7:0]       rd_data_o,
    // status
    output logic             cont_o
);
    import quad_read_pkg::*;

    phase_e      ph_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  half_reg;
    logic        sck_reg;
    logic        cs_n_reg;
    logic        oe_n_reg;
    logic [47:0] tx_reg;
    logic [47:0] tx_load;
    logic        wide_reg;
    logic        stay_reg;
    logic        qpi_reg;
    logic [3:0]  lat_reg;
    logic [7:0]  left_reg;
    logic        nib_lo_reg;
    logic [3:0]  hi_reg;
    logic        push_reg;
    logic [7:0]  push_data_reg;
    logic        cont_reg;
    logic        fifo_ready;
    logic        tick;
    logic        fall;
    logic        last_cyc;
    logic        wide_now;
    logic [7:0]  mode_byte;

    assign tick        = (half_reg == SCK_HALF_LAST);
    assign fall        = tick && sck_reg;
    assign req_ready_o = (ph_reg == PH_IDLE) && cs_n_reg;
    // R1 wide opcode or wide config gives four address bytes
    assign wide_now    = req_wide_i || cfg_addr4_i;
    // R10 mode nibble A asks the device to stay
    assign mode_byte   = {req_stay_i ? MODE_KEEP : MODE_EXIT, MODE_LOW};

    // opcode, address and mode queued msb first
    always_comb begin
        tx_load = wide_now ? {req_addr_i, mode_byte, 8'h00}
                           : {req_addr_i[23:0], mode_byte, 16'h0000};
        if (!cont_reg) begin
            tx_load = {req_wide_i ? OP_QREAD_WIDE : OP_QREAD, tx_load[47:8]};
        end
    end

    // last cycle of the current counted phase
    always_comb begin
        unique case (ph_reg)
            PH_OPC:   last_cyc = (cnt_reg == opc_cycles(qpi_reg) - 4'h1);
            PH_ADDR:  last_cyc = (cnt_reg == adr_cycles(wide_reg) - 4'h1);
            PH_MODE:  last_cyc = (cnt_reg == MODE_CYC - 4'h1);
            PH_DUMMY: last_cyc = (cnt_reg == lat_reg - 4'h1);
            default:  last_cyc = 1'b0;
        endcase
    end

    // half-period timer keeps the serial clock within its limit
    // R4 divider derived from the maximum clock rate
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            half_reg <= 4'h0;
        end else begin
            half_reg <= tick ? 4'h0 : half_reg + 4'h1;
        end
    end

    // serial clock; held low in the data phase while the buffer is full (back-pressure)
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sck_reg <= 1'b0;
        end else if (tick && !cs_n_reg && ph_reg != PH_IDLE) begin
            if (sck_reg || ph_reg != PH_DATA || fifo_ready) begin
                sck_reg <= !sck_reg;
            end
        end
    end

    // frame sequencing; select and line drive start on request accept, later host outputs change at falling edges
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ph_reg   <= PH_IDLE;
            cnt_reg  <= 4'h0;
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            tx_reg   <= '0;
            wide_reg <= 1'b0;
            stay_reg <= 1'b0;
            qpi_reg  <= 1'b0;
            lat_reg  <= 4'h0;
            left_reg <= 8'h00;
            cont_reg <= 1'b0;
        end else if (ph_reg == PH_IDLE) begin
            cs_n_reg <= 1'b1;
            if (req_valid_i && req_ready_o) begin
                // R19 opcode skipped while continuous
                ph_reg   <= cont_reg ? PH_ADDR : PH_OPC;
                cnt_reg  <= 4'h0;
                cs_n_reg <= 1'b0;
                oe_n_reg <= 1'b0;
                tx_reg   <= tx_load;
                wide_reg <= wide_now;
                stay_reg <= req_stay_i;
                qpi_reg  <= cfg_qpi_i;
                lat_reg  <= cfg_latency_i;
                left_reg <= req_len_i;
            end
        end else if (fall) begin
            cnt_reg <= last_cyc ? 4'h0 : cnt_reg + 4'h1;
            // R18 opcode one bit, or a nibble in four-line protocol
            // R21 msb first
            tx_reg  <= (ph_reg == PH_OPC && !qpi_reg) ? {tx_reg[46:0], 1'b0}
                                                     : {tx_reg[43:0], 4'h0};
            if (last_cyc) begin
                unique case (ph_reg)
                    PH_OPC:  ph_reg <= PH_ADDR;
                    // R14 mode follows the address
                    PH_ADDR: ph_reg <= PH_MODE;
                    PH_MODE: begin
                        // R15 lines released before data returns
                        // R16 released right after the mode cycles
                        oe_n_reg <= 1'b1;
                        ph_reg   <= (lat_reg == 4'h0) ? PH_DATA : PH_DUMMY;
                    end
                    default: ph_reg <= PH_DATA;
                endcase
            end
            if (ph_reg == PH_DATA && nib_lo_reg && left_reg <= 8'h01) begin
                // R17 select rises only inside the data phase
                ph_reg   <= PH_IDLE;
                cs_n_reg <= 1'b1;
                cont_reg <= stay_reg;
            end
            if (ph_reg == PH_DATA && nib_lo_reg) begin
                left_reg <= left_reg - 8'h01;
            end
        end
    end

    // nibble pairing of returned data, upper nibble first
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nib_lo_reg    <= 1'b0;
            hi_reg        <= 4'h0;
            push_reg      <= 1'b0;
            push_data_reg <= 8'h00;
        end else begin
            push_reg <= 1'b0;
            if (ph_reg != PH_DATA) begin
                nib_lo_reg <= 1'b0;
            end else if (fall) begin
                nib_lo_reg <= !nib_lo_reg;
                if (nib_lo_reg) begin
                    push_reg      <= 1'b1;
                    push_data_reg <= {hi_reg, link.io_line};
                end else begin
                    hi_reg <= link.io_line;
                end
            end
        end
    end

    // byte buffer toward the user
    quad_read_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_reg),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_data_reg),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    // link outputs; serial opcode uses line zero only
    assign link.cs_n         = cs_n_reg;
    assign link.sck          = sck_reg;
    assign link.host_io      = (ph_reg == PH_OPC && !qpi_reg) ? {3'b000, tx_reg[47]}
                                                              : tx_reg[47:44];
    assign link.host_io_oe_n = oe_n_reg;
    assign cont_o            = cont_reg;

endmodule
`default_nettype wire

// file: hw/quad_read_if.sv
// link wires between the flash controller and the flash device
`timescale 1ns/1ps
`default_nettype none
interface quad_read_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io;
    logic       host_io_oe_n;
    logic [3:0] dev_io;
    logic       dev_io_oe_n;
    logic [3:0] io_line;

    // resolved line level; undriven lines float high through pull-ups
    assign io_line = !host_io_oe_n ? host_io :
                     (!dev_io_oe_n ? dev_io : 4'hF);

    modport host (output cs_n, sck, host_io, host_io_oe_n, input io_line);
    modport dev  (input cs_n, sck, io_line, output dev_io, dev_io_oe_n);
endinterface
`default_nettype wire

// file: hw/quad_read_pkg.sv
// shared constants and types for the quad-line continuous read link
package quad_read_pkg;

    // opcodes seen by the device
    localparam logic [7:0] OP_QREAD      = 8'hEB;
    localparam logic [7:0] OP_QREAD_WIDE = 8'hEC;
    localparam logic [7:0] OP_MODE_RST   = 8'hFF;

    // mode byte upper nibble that keeps continuous read
    localparam logic [3:0] MODE_KEEP = 4'hA;
    localparam logic [3:0] MODE_EXIT = 4'h0;
    localparam logic [3:0] MODE_LOW  = 4'h0;

    // phase lengths in serial clock cycles
    localparam logic [3:0] OPC_CYC_SER = 4'h8;
    localparam logic [3:0] OPC_CYC_QPI = 4'h2;
    localparam logic [3:0] ADR_CYC_3B  = 4'h6;
    localparam logic [3:0] ADR_CYC_4B  = 4'h8;
    localparam logic [3:0] MODE_CYC    = 4'h2;

    // array size of the modelled memory, in address bits
    localparam int MEM_AW = 10;

    // serial clock limit and derived half period in system clocks
    localparam int CLK_MHZ      = 50;
    localparam int SCK_MAX_MHZ  = 133;
    localparam int SCK_HALF_CYC = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
    localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

    // read data buffer
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    // frame phases
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_OPC    = 3'b001,
        PH_ADDR   = 3'b010,
        PH_MODE   = 3'b011,
        PH_DUMMY  = 3'b100,
        PH_DATA   = 3'b101,
        PH_IGNORE = 3'b110
    } phase_e;

    // cycles in the opcode phase
    function automatic logic [3:0] opc_cycles(input logic all_four_line_protocol);
        return all_four_line_protocol ? OPC_CYC_QPI : OPC_CYC_SER;
    endfunction

    // cycles in the address phase
    function automatic logic [3:0] adr_cycles(input logic wide);
        return wide ? ADR_CYC_4B : ADR_CYC_3B;
    endfunction

endpackage

// file: verif/quad_read_asserts.sv
// link protocol checker for the quad read link
`timescale 1ns/1ps
`default_nettype none
module quad_read_asserts (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    // link wires
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       host_io_oe_n,
    input wire logic       dev_io_oe_n,
    input wire logic [3:0] io_line
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // deselect gap of two clocks at least
    sequence gap_s;
        cs_n [*2];
    endsequence
    one_driver_a: assert property (
        host_io_oe_n || dev_io_oe_n) else $error("both ends drive the lines");
    sck_idle_a: assert property (
        cs_n |-> !sck) else $error("serial clock high while deselected");
    dev_quiet_a: assert property (
        cs_n && $past(cs_n) |-> dev_io_oe_n) else $error("device drives while deselected");
    host_quiet_a: assert property (
        cs_n && $past(cs_n) |-> host_io_oe_n) else $error("host drives while deselected");
    frame_gap_a: assert property (
        $rose(cs_n) |-> gap_s) else $error("deselect gap too short");
    frame_start_a: assert property (
        $fell(cs_n) |-> !sck && !host_io_oe_n) else $error("bad frame start");
    turn_around_a: assert property (
        $fell(dev_io_oe_n) |-> $past(host_io_oe_n)) else $error("no turnaround gap");
    data_on_fall_a: assert property (
        !dev_io_oe_n && !$past(dev_io_oe_n) && $changed(io_line) |-> !$past(sck))
        else $error("device data changed off the falling edge");
    host_hold_a: assert property (
        $rose(sck) && !host_io_oe_n |-> $stable(io_line)) else $error("host nibble moved at rise");
    sel_rise_a: assert property (
        $rose(cs_n) |-> $past(host_io_oe_n)) else $error("select rose while host drives");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import quad_read_pkg::*;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, qen = 1'b1, a4 = 1'b0, all_four_line_protocol = 1'b0, ld = 1'b0;
    logic        rv = 1'b0, wide = 1'b0, stay = 1'b0, rdy = 1'b1;
    logic        cont, rq_rdy, rd_v, hcont, rdg;
    logic [3:0]  lat = 4'h2;
    logic [9:0]  ld_a = 10'h000;
    logic [7:0]  ld_d = 8'h00, len = 8'h01, rd_d;
    logic [31:0] adr = 32'h0;
    int          fail_count = 0, compares = 0;
    quad_read_if lk ();
    quad_read_dev i_quad_read_dev (.clk_sys_i, .rst_i, .link(lk.dev), .quad_en_i(qen),
        .addr4_i(a4), .all_four_line_protocol_i(all_four_line_protocol), .latency_i(lat), .load_en_i(ld),
        .load_addr_i(ld_a), .load_data_i(ld_d), .cont_mode_o(cont), .reading_o(rdg));
    quad_read_host i_quad_read_host (.clk_sys_i, .rst_i, .link(lk.host), .req_valid_i(rv),
        .req_ready_o(rq_rdy), .req_addr_i(adr), .req_wide_i(wide), .req_stay_i(stay),
        .req_len_i(len), .cfg_addr4_i(a4), .cfg_qpi_i(all_four_line_protocol), .cfg_latency_i(lat),
        .rd_valid_o(rd_v), .rd_ready_i(rdy), .rd_data_o(rd_d), .cont_o(hcont));
    quad_read_asserts i_quad_read_asserts (.clk_sys_i, .rst_i, .cs_n(lk.cs_n), .sck(lk.sck),
        .host_io_oe_n(lk.host_io_oe_n), .dev_io_oe_n(lk.dev_io_oe_n), .io_line(lk.io_line));
    // 50 MHz clock
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // array contents, mixed so a stuck address shows
    function automatic logic [7:0] pat(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h2B};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one read; ff expects the floating-high lines
    task automatic rd(input logic [31:0] a, input logic w, input logic s, input logic [7:0] n,
                      input logic ff);
        int k;
        k = 0;
        @(negedge clk_sys_i);
        while (rq_rdy !== 1'b1 && k < 300) begin
            @(negedge clk_sys_i);
            k++;
        end
        if (rq_rdy !== 1'b1) begin
            fail_count++;
            close_out();
        end
        @(posedge clk_sys_i);
        adr <= a;
        wide <= w;
        stay <= s;
        len <= n;
        rv <= 1'b1;
        @(posedge clk_sys_i);
        rv <= 1'b0;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge clk_sys_i);
            while (!(rd_v === 1'b1 && rdy === 1'b1) && k < 2000) begin
                @(negedge clk_sys_i);
                k++;
            end
            if (k == 2000) begin
                fail_count++;
                close_out();
            end
            chk(rd_d, ff ? 8'hFF : pat(10'(a + 32'(i))));
            @(posedge clk_sys_i);
        end
    endtask
    task automatic cfg(input logic q, input logic w4, input logic p, input logic [3:0] l);
        @(posedge clk_sys_i);
        qen <= q;
        a4 <= w4;
        all_four_line_protocol <= p;
        lat <= l;
    endtask
    task automatic t_wrap();
        rd(32'h3FE, 1'b0, 1'b0, 8'h04, 1'b0);
    endtask
    task automatic t_cont();
        rd(32'h10, 1'b0, 1'b1, 8'h02, 1'b0);
        chk({6'h0, hcont, cont}, 8'h03);
        rd(32'h123, 1'b0, 1'b1, 8'h01, 1'b0);
        rd(32'h40, 1'b0, 1'b0, 8'h01, 1'b0);
        chk({5'h0, rdg, hcont, cont}, 8'h00);
    endtask
    task automatic t_widths();
        cfg(1'b1, 1'b0, 1'b0, 4'h3);
        rd(32'h200, 1'b1, 1'b0, 8'h03, 1'b0);
        cfg(1'b1, 1'b1, 1'b0, 4'h0);
        rd(32'h1FF, 1'b0, 1'b0, 8'h02, 1'b0);
        cfg(1'b1, 1'b0, 1'b1, 4'h2);
        rd(32'h2A0, 1'b0, 1'b0, 8'h02, 1'b0);
        cfg(1'b0, 1'b0, 1'b0, 4'h2);
        rd(32'h55, 1'b0, 1'b0, 8'h02, 1'b1);
        cfg(1'b1, 1'b0, 1'b0, 4'h2);
    endtask
    // stalled drain: fifo fills, sck must stop
    task automatic t_fifo();
        @(posedge clk_sys_i);
        rdy <= 1'b0;
        fork
            rd(32'h300, 1'b0, 1'b0, 8'h14, 1'b0);
            begin
                repeat (600) @(posedge clk_sys_i);
                rdy <= 1'b1;
            end
        join
    endtask
    task automatic t_mrst();
        rd(32'h10, 1'b0, 1'b1, 8'h01, 1'b0);
        rd(32'hFF0000, 1'b0, 1'b1, 8'h01, 1'b1);
        chk({7'h0, cont}, 8'h00);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(32'h77, 1'b0, 1'b0, 8'h01, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 1024; i++) begin
            @(posedge clk_sys_i);
            ld <= 1'b1;
            ld_a <= 10'(i);
            ld_d <= pat(10'(i));
        end
        @(posedge clk_sys_i);
        ld <= 1'b0;
        t_wrap();
        t_cont();
        t_widths();
        t_fifo();
        t_mrst();
        close_out();
    end
endmodule
`default_nettype wire
